// ===== rtl/mimc_top.sv
/*
 * Interrupt mask and miscellaneous configuration registers of a hardware
 * monitor: two mask registers, spare register, intrusion-clear pulse,
 * voltage-id / fan divisor, top id bit and second configuration register.
 * Assumes a serial-bus front end giving one-cycle read and write strobes;
 * status flags, first config enable and channel mode come from outside.
 */
`timescale 1ns/1ps

module mimc_top #(
	parameter int unsigned PULSE_CYCLES = mimc_pkg::INTR_PULSE_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// register port from serial front end
	input wire logic [mimc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// bits held in neighbouring registers
	input wire logic int_out_en,
	input wire logic soft_reinit,
	input wire logic shared_pin_irq_mode,
	// status flags
	input wire logic [7:0] status_first,
	input wire logic [7:0] status_second,
	// pins
	input wire logic [3:0] voltage_id_low,
	input wire logic voltage_id_top,
	input wire logic intrusion_in,
	output logic intrusion_out,
	output logic intrusion_oe,
	output logic int_n,
	// configuration outputs
	output logic [3:0] fan_a_divisor,
	output logic [3:0] fan_b_divisor,
	output logic thermal_out_mode,
	output logic int_hi_limit_lock,
	output logic ext_hi_limit_lock,
	output logic int_hi_limit_wr,
	output logic ext_hi_limit_wr,
	output logic [7:0] limit_wdata
);
	import mimc_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0] mask1;
		logic [7:0] mask2;
		logic [7:0] spare;
		logic [7:0] intr_clr;
		logic [3:0] fan_div;
		logic [6:0] vid_top_rsv;
		logic [7:0] cfg2;
		logic [7:0] rdata;
		logic [3:0] fan_a_ratio;
		logic [3:0] fan_b_ratio;
		logic int_lim_wr;
		logic ext_lim_wr;
		logic [7:0] lim_wdata;
		logic pin_out;
	} mimc_regs_t;

	localparam mimc_regs_t REGS_RST = '{
		mask1: RST_MASK,
		mask2: RST_MASK,
		spare: RST_SPARE,
		intr_clr: RST_INTR_CLEAR,
		fan_div: RST_FAN_DIV,
		vid_top_rsv: RST_VID_TOP_RSV,
		cfg2: RST_CFG_SECOND,
		rdata: 8'h00,
		fan_a_ratio: div_ratio(RST_FAN_DIV[1:0]),
		fan_b_ratio: div_ratio(RST_FAN_DIV[3:2]),
		int_lim_wr: 1'b0,
		ext_lim_wr: 1'b0,
		lim_wdata: 8'h00,
		pin_out: 1'b0
	};

	mimc_regs_t regs_r;
	mimc_regs_t regs_nxt;
	logic pulse_start;
	logic pulse_active;
	logic pulse_done;
	logic [1:0] ext_irq;

	// write strobe aimed at one offset
	function automatic logic wr_to(input logic [6:0] ofs);
		wr_to = reg_wr_en && (reg_addr == ofs);
	endfunction

	// ****************************************************************
	// register file
	// ****************************************************************

	// a one written to the pulse bit starts the intrusion-clear pulse
	assign pulse_start = wr_to(OFS_INTR_CLEAR)
		&& reg_wdata[INTR_PULSE_BIT];

	// next-state of every register; reinit beats a write in the same cycle, except a write to the spare register
	always_comb begin
		regs_nxt = regs_r;
		regs_nxt.int_lim_wr = 1'b0;
		regs_nxt.ext_lim_wr = 1'b0;
		// self clear first so a fresh write of one still wins
		if (pulse_done) begin
			regs_nxt.intr_clr[INTR_PULSE_BIT] = 1'b0;
		end
		if (reg_wr_en) begin
			case (reg_addr)
				OFS_MASK_FIRST: begin
					regs_nxt.mask1 = reg_wdata;
				end
				OFS_MASK_SECOND: begin
					regs_nxt.mask2 = reg_wdata;
				end
				OFS_LEGACY_SPARE: begin
					regs_nxt.spare = reg_wdata;
				end
				OFS_INTR_CLEAR: begin
					regs_nxt.intr_clr = reg_wdata;
				end
				OFS_VID_FAN: begin
					regs_nxt.fan_div = reg_wdata[7:4];
				end
				OFS_VID_TOP: begin
					regs_nxt.vid_top_rsv = reg_wdata[7:1];
				end
				OFS_CFG_SECOND: begin
					// lock bits are sticky: a write can set but never clear
					regs_nxt.cfg2 = (reg_wdata & C2_WR_MASK)
						| (regs_r.cfg2 & C2_ONCE_MASK);
				end
				OFS_INT_HI_LIM: begin
					regs_nxt.int_lim_wr = ~regs_r.cfg2[C2_INT_LOCK];
					regs_nxt.lim_wdata = reg_wdata;
				end
				OFS_EXT_HI_LIM: begin
					regs_nxt.ext_lim_wr = ~regs_r.cfg2[C2_EXT_LOCK];
					regs_nxt.lim_wdata = reg_wdata;
				end
				default: begin
				end
			endcase
		end
		// software reinit restores defaults of all but the spare register and drops the limit locks
		if (soft_reinit) begin
			regs_nxt.mask1 = REGS_RST.mask1;
			regs_nxt.mask2 = REGS_RST.mask2;
			regs_nxt.intr_clr = REGS_RST.intr_clr;
			regs_nxt.fan_div = REGS_RST.fan_div;
			regs_nxt.vid_top_rsv = REGS_RST.vid_top_rsv;
			regs_nxt.cfg2 = REGS_RST.cfg2;
			regs_nxt.int_lim_wr = 1'b0;
			regs_nxt.ext_lim_wr = 1'b0;
		end
		// read data, captured on the strobe and held until the next read
		if (reg_rd_en) begin
			case (reg_addr)
				OFS_MASK_FIRST: regs_nxt.rdata = regs_r.mask1;
				OFS_MASK_SECOND: regs_nxt.rdata = regs_r.mask2;
				OFS_LEGACY_SPARE: regs_nxt.rdata = regs_r.spare;
				OFS_INTR_CLEAR: regs_nxt.rdata = regs_r.intr_clr;
				OFS_VID_FAN: begin
					regs_nxt.rdata = {regs_r.fan_div, voltage_id_low};
				end
				OFS_VID_TOP: begin
					regs_nxt.rdata = {regs_r.vid_top_rsv, voltage_id_top};
				end
				OFS_CFG_SECOND: regs_nxt.rdata = regs_r.cfg2;
				default: regs_nxt.rdata = 8'h00;
			endcase
		end
		regs_nxt.fan_a_ratio = div_ratio(regs_nxt.fan_div[1:0]);
		regs_nxt.fan_b_ratio = div_ratio(regs_nxt.fan_div[3:2]);
		regs_nxt.pin_out = 1'b0; // pulse only ever pulls low
	end

	// state register; power-on reset loads documented defaults
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regs_r <= REGS_RST;
		end else begin
			regs_r <= regs_nxt;
		end
	end

	// ****************************************************************
	// intrusion pulse and interrupt output
	// ****************************************************************
	mimc_pulse_timer #(
		.PULSE_CYCLES(PULSE_CYCLES),
		.CNT_W(PULSE_CNT_W)
	) u_pulse (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.start(pulse_start),
		.active(pulse_active),
		.done(pulse_done)
	);

	// shared pins count only in interrupt mode and with their own enable
	assign ext_irq[0] = shared_pin_irq_mode & regs_r.cfg2[C2_IRQ3_EN]
		& voltage_id_low[3];
	assign ext_irq[1] = shared_pin_irq_mode & regs_r.cfg2[C2_IRQ4_EN]
		& voltage_id_top;

	mimc_irq_gate u_gate (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.int_en(int_out_en),
		.mask_first(regs_r.mask1),
		.mask_second(regs_r.mask2),
		.thermal_alarm_n_mask(regs_r.cfg2[C2_THERMAL_ALARM_N_MASK]),
		.status_first(status_first),
		.status_second(status_second),
		.ext_irq(ext_irq),
		.int_n(int_n)
	);

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign reg_rdata = regs_r.rdata;
	assign intrusion_out = regs_r.pin_out;
	assign intrusion_oe = pulse_active;
	assign fan_a_divisor = regs_r.fan_a_ratio;
	assign fan_b_divisor = regs_r.fan_b_ratio;
	assign thermal_out_mode = regs_r.cfg2[C2_THERMAL_ALARM_N_MODE];
	assign int_hi_limit_lock = regs_r.cfg2[C2_INT_LOCK];
	assign ext_hi_limit_lock = regs_r.cfg2[C2_EXT_LOCK];
	assign int_hi_limit_wr = regs_r.int_lim_wr;
	assign ext_hi_limit_wr = regs_r.ext_lim_wr;
	assign limit_wdata = regs_r.lim_wdata;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// helper: length of the current low pulse on the intrusion pin
	logic [PULSE_CNT_W:0] oe_len;
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !intrusion_oe) begin
			oe_len <= '0;
		end else begin
			oe_len <= oe_len + (PULSE_CNT_W+1)'(1);
		end
	end

	a_mask_all_quiet: assert property (
		(regs_r.mask1 == 8'hFF && regs_r.mask2 == 8'hFF && ext_irq == 2'b00)
		|=> int_n)
		else $error("fully masked flags still drove the interrupt");

	a_int_disabled: assert property (
		!int_out_en |=> int_n)
		else $error("interrupt asserted while output disabled");

	a_int_unmasked: assert property (
		(int_out_en && |(status_first & ~regs_r.mask1)) |=> !int_n)
		else $error("unmasked first flag did not assert interrupt");

	a_thermal_alarm_n_masked: assert property (
		(regs_r.cfg2[C2_THERMAL_ALARM_N_MASK] && status_first == 8'h00
		&& status_second == 8'h20 && ext_irq == 2'b00) |=> int_n)
		else $error("thermal event reached interrupt while masked");

	a_reset_values: assert property (
		$past(sys_rst) |-> (regs_r.mask1 == 8'h00 && regs_r.mask2 == 8'h00
		&& regs_r.intr_clr == 8'h00 && regs_r.cfg2 == 8'h00
		&& regs_r.fan_div == RST_FAN_DIV))
		else $error("register not at default after reset");

	a_pulse_start: assert property (
		(pulse_start && !intrusion_oe) |=> intrusion_oe && !intrusion_out)
		else $error("intrusion pulse did not start");

	a_pulse_length: assert property (
		$fell(intrusion_oe) |-> $past(oe_len) >= (PULSE_CNT_W+1)'(PULSE_CYCLES - 1))
		else $error("intrusion pulse shorter than minimum");

	a_pulse_selfclr: assert property (
		($fell(intrusion_oe) && !wr_to(OFS_INTR_CLEAR) && !soft_reinit)
		|=> !regs_r.intr_clr[INTR_PULSE_BIT])
		else $error("intrusion-clear bit did not self clear");

	a_int_lock: assert property (
		(regs_r.cfg2[C2_INT_LOCK] && wr_to(OFS_INT_HI_LIM)) |=> !int_hi_limit_wr)
		else $error("locked internal limit was written");

	a_ext_lock: assert property (
		(regs_r.cfg2[C2_EXT_LOCK] && wr_to(OFS_EXT_HI_LIM)) |=> !ext_hi_limit_wr)
		else $error("locked external limit was written");

	a_lock_sticky: assert property (
		(regs_r.cfg2[C2_INT_LOCK] && !soft_reinit) |=> regs_r.cfg2[C2_INT_LOCK])
		else $error("internal lock cleared without reinit");

	a_reinit_unlock: assert property (
		soft_reinit |=> !int_hi_limit_lock && !ext_hi_limit_lock)
		else $error("reinit left a limit lock set");

	a_vid_read: assert property (
		(reg_rd_en && reg_addr == OFS_VID_FAN)
		|=> reg_rdata[3:0] == $past(voltage_id_low))
		else $error("id pins not reflected in read data");

	a_fan_ratio: assert property (
		wr_to(OFS_VID_FAN) && !soft_reinit
		|=> fan_a_divisor == (4'h1 << $past(reg_wdata[5:4]))
		&& fan_b_divisor == (4'h1 << $past(reg_wdata[7:6])))
		else $error("fan divisor ratio wrong after write");

	c_pulse_run: cover property (pulse_start ##1 intrusion_oe);
	c_locked_write: cover property (
		regs_r.cfg2[C2_INT_LOCK] && wr_to(OFS_INT_HI_LIM));
	c_int_fire: cover property (int_n ##1 !int_n);
	c_ext_irq: cover property (|ext_irq ##1 !int_n);

endmodule // mimc_top

// ===== rtl/mimc_pkg.sv
/*
 * Constants shared by the monitor interrupt-mask and configuration block:
 * register offsets, field positions, reset values and pulse timing.
 * Assumes a serial-bus front end that turns bus transactions into
 * single-cycle register read and write strobes on ref_clk.
 */

package mimc_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam int unsigned ADDR_W = 7;
	localparam logic [6:0] OFS_EXT_HI_LIM = 7'h37;
	localparam logic [6:0] OFS_INT_HI_LIM = 7'h39;
	localparam logic [6:0] OFS_MASK_FIRST = 7'h43;
	localparam logic [6:0] OFS_MASK_SECOND = 7'h44;
	localparam logic [6:0] OFS_LEGACY_SPARE = 7'h45;
	localparam logic [6:0] OFS_INTR_CLEAR = 7'h46;
	localparam logic [6:0] OFS_VID_FAN = 7'h47;
	localparam logic [6:0] OFS_VID_TOP = 7'h49;
	localparam logic [6:0] OFS_CFG_SECOND = 7'h4A;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int unsigned INTR_PULSE_BIT = 7;
	localparam int unsigned FAN_A_LSB = 4;
	localparam int unsigned FAN_B_LSB = 6;
	localparam int unsigned C2_THERMAL_ALARM_N_MASK = 0;
	localparam int unsigned C2_INT_LOCK = 1;
	localparam int unsigned C2_EXT_LOCK = 2;
	localparam int unsigned C2_THERMAL_ALARM_N_MODE = 3;
	localparam int unsigned C2_IRQ3_EN = 6;
	localparam int unsigned C2_IRQ4_EN = 7;
	localparam int unsigned S2_THERMAL_ALARM_N = 5;
	localparam logic [7:0] C2_WR_MASK = 8'hCF; // bits 4,5 reserved
	localparam logic [7:0] C2_ONCE_MASK = 8'h06; // write-once locks
	localparam logic [7:0] S2_RSV_MASK = 8'h0C; // reserved status bits

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_SPARE = 8'h00;
	localparam logic [7:0] RST_INTR_CLEAR = 8'h00;
	localparam logic [3:0] RST_FAN_DIV = 4'h5;
	localparam logic [6:0] RST_VID_TOP_RSV = 7'h40;
	localparam logic [7:0] RST_CFG_SECOND = 8'h00;

	// ****************************************************************
	// intrusion pulse timing
	// ****************************************************************
	localparam longint INTR_PULSE_MIN_MS = 20;
	localparam longint CLK_MHZ = 200;
	localparam longint CLK_TOL_PCT = 5; // margin for oscillator spread
	localparam int unsigned INTR_PULSE_CYCLES = int'((INTR_PULSE_MIN_MS
		* 1000 * CLK_MHZ * (100 + CLK_TOL_PCT) + 99) / 100);
	localparam int unsigned PULSE_CNT_W = 23;

	// divisor field to ratio: 00->1, 01->2, 10->4, 11->8
	function automatic logic [3:0] div_ratio(input logic [1:0] fld);
		div_ratio = 4'h1 << fld;
	endfunction

endpackage

// ===== rtl/mimc_pulse_timer.sv
/*
 * Intrusion-clear pulse timer: holds active for a fixed count of cycles
 * after start, then gives a one-cycle done.
 * Assumes start is a single-cycle strobe; a start while active is ignored.
 */
`timescale 1ns/1ps

module mimc_pulse_timer #(
	parameter int unsigned PULSE_CYCLES = mimc_pkg::INTR_PULSE_CYCLES,
	parameter int unsigned CNT_W = mimc_pkg::PULSE_CNT_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// control
	input wire logic start,
	output logic active,
	output logic done
);
	import mimc_pkg::*;

	typedef struct packed {
		logic active;
		logic done;
		logic [CNT_W-1:0] cnt;
	} mimc_tmr_t;

	mimc_tmr_t tmr_r;
	mimc_tmr_t tmr_nxt;

	// count down; done lands on the edge that drops active
	always_comb begin
		tmr_nxt = tmr_r;
		tmr_nxt.done = 1'b0;
		if (tmr_r.active) begin
			if (tmr_r.cnt == CNT_W'(1)) begin
				tmr_nxt.active = 1'b0;
				tmr_nxt.done = 1'b1;
			end else begin
				tmr_nxt.cnt = tmr_r.cnt - CNT_W'(1);
			end
		end else if (start) begin
			tmr_nxt.active = 1'b1;
			tmr_nxt.cnt = CNT_W'(PULSE_CYCLES);
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tmr_r <= '0;
		end else begin
			tmr_r <= tmr_nxt;
		end
	end

	assign active = tmr_r.active;
	assign done = tmr_r.done;

endmodule // mimc_pulse_timer

// ===== rtl/mimc_irq_gate.sv
/*
 * Combines status flags, mask registers and extra interrupt pins into
 * the registered active-low interrupt output.
 * Assumes status flags come from the limit comparators, level per flag.
 */
`timescale 1ns/1ps

module mimc_irq_gate (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// enables and masks
	input wire logic int_en,
	input wire logic [7:0] mask_first,
	input wire logic [7:0] mask_second,
	input wire logic thermal_alarm_n_mask,
	// sources
	input wire logic [7:0] status_first,
	input wire logic [7:0] status_second,
	input wire logic [1:0] ext_irq,
	// output
	output logic int_n
);
	import mimc_pkg::*;

	typedef struct packed {
		logic int_n;
	} mimc_gate_t;

	mimc_gate_t g_r;
	mimc_gate_t g_nxt;
	logic [7:0] live_second;
	logic any_src;

	// a one in a mask removes the flag; reserved status bits never count
	always_comb begin
		live_second = status_second & ~mask_second & ~S2_RSV_MASK;
		live_second[S2_THERMAL_ALARM_N] = live_second[S2_THERMAL_ALARM_N] & ~thermal_alarm_n_mask;
		any_src = |(status_first & ~mask_first) | (|live_second)
			| (|ext_irq);
		g_nxt.int_n = ~(int_en & any_src);
	end

	// registered so the pin never glitches on mask writes
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			g_r.int_n <= 1'b1;
		end else begin
			g_r <= g_nxt;
		end
	end

	assign int_n = g_r.int_n;

endmodule // mimc_irq_gate

// ===== verification/mimc_host_model.sv
/*
 * Host side of the register port: byte reads and writes, and the
 * reinit bit of the first configuration register.
 * Assumes one-cycle strobes sampled on the rising edge of ref_clk.
 */
`timescale 1ns/1ps

module mimc_host_model (
	// clock
	input wire logic ref_clk,
	// register port
	output logic [mimc_pkg::ADDR_W-1:0] reg_addr,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// first configuration reinit
	output logic soft_reinit
);
	import mimc_pkg::*;

	// ****************************************************************
	// idle state
	// ****************************************************************
	initial begin
		reg_addr = 7'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wdata = 8'h00;
		soft_reinit = 1'b0;
	end

	// write strobe lasts one edge; data inverts after so no stale match
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge ref_clk);
		reg_wr_en <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// read data is registered, so take it once the strobe edge landed
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge ref_clk);
		reg_rd_en <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// only way to drop the limit locks short of a power cycle
	task automatic reinit();
		@(posedge ref_clk);
		soft_reinit <= 1'b1;
		@(posedge ref_clk);
		soft_reinit <= 1'b0;
	endtask
endmodule // mimc_host_model

// ===== verification/tb_monitor_irq_mask_config.sv
/*
 * Self-checking bench for the interrupt mask and configuration block.
 * Assumes the host model for the register port and a shortened pulse.
 */
`timescale 1ns/1ps

module tb_monitor_irq_mask_config;
	import mimc_pkg::*;

	localparam int unsigned PULSE = 20; // shortened intrusion pulse
	logic ref_clk, sys_rst, reg_wr_en, reg_rd_en, soft_reinit;
	logic [6:0] reg_addr, a;
	logic [7:0] reg_wdata, reg_rdata, status_first, status_second;
	logic [7:0] limit_wdata, lim_d, d, m;
	logic [3:0] voltage_id_low, fan_a_divisor, fan_b_divisor;
	logic int_out_en, shared_pin_irq_mode, voltage_id_top, int_n;
	logic intrusion_out, intrusion_oe, thermal_out_mode;
	logic int_hi_limit_lock, ext_hi_limit_lock;
	logic int_hi_limit_wr, ext_hi_limit_wr;
	wire logic intrusion_in;
	int fails, checks, oe_cnt, iw_cnt, ew_cnt, i, n;
	logic [6:0] rst_a [8] = '{7'h43, 7'h44, 7'h45, 7'h46, 7'h4A,
		7'h47, 7'h49, 7'h7F};
	logic [7:0] rst_e [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h5A, 8'h81, 8'h00};

	// pin has a pull-up, low only while the block pulls it
	assign intrusion_in = intrusion_oe ? intrusion_out : 1'b1;

	mimc_host_model mimc_host_model_inst (.ref_clk(ref_clk),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .soft_reinit(soft_reinit));

	mimc_top #(.PULSE_CYCLES(PULSE)) mimc_top_inst (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .int_out_en(int_out_en),
		.soft_reinit(soft_reinit),
		.shared_pin_irq_mode(shared_pin_irq_mode),
		.status_first(status_first), .status_second(status_second),
		.voltage_id_low(voltage_id_low), .voltage_id_top(voltage_id_top),
		.intrusion_in(intrusion_in), .intrusion_out(intrusion_out),
		.intrusion_oe(intrusion_oe), .int_n(int_n),
		.fan_a_divisor(fan_a_divisor), .fan_b_divisor(fan_b_divisor),
		.thermal_out_mode(thermal_out_mode),
		.int_hi_limit_lock(int_hi_limit_lock),
		.ext_hi_limit_lock(ext_hi_limit_lock),
		.int_hi_limit_wr(int_hi_limit_wr),
		.ext_hi_limit_wr(ext_hi_limit_wr), .limit_wdata(limit_wdata));

	// ****************************************************************
	// clock, monitors and checks
	// ****************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// limit write strobes are one cycle wide, so count them as they pass; oe_cnt counts pulse cycles
	always @(posedge ref_clk) begin
		if (intrusion_oe === 1'b1) oe_cnt++;
		if (ext_hi_limit_wr === 1'b1) ew_cnt++;
		if (int_hi_limit_wr === 1'b1) begin
			iw_cnt++;
			lim_d = limit_wdata;
		end
	end

	task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	task automatic chk1(input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// drive the flag inputs, then let the registered output settle
	task automatic src(input logic [7:0] sf, input logic [7:0] ss);
		@(posedge ref_clk);
		status_first <= sf;
		status_second <= ss;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		sys_rst = 1'b1;
		int_out_en = 1'b0;
		shared_pin_irq_mode = 1'b0;
		status_first = 8'h00;
		status_second = 8'h00;
		voltage_id_low = 4'hA;
		voltage_id_top = 1'b1;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		foreach (rst_a[k]) begin
			mimc_host_model_inst.rd(rst_a[k], d);
			chk8(rst_e[k], d);
		end
		chk8(8'h22, {fan_b_divisor, fan_a_divisor});
		$display("test reset_values done");
		// plain storage, reserved bits included
		foreach (rst_a[k]) begin
			if (k > 3) continue;
			m = (k == 3) ? 8'h7F : 8'hA5;
			mimc_host_model_inst.wr(rst_a[k], m);
			mimc_host_model_inst.rd(rst_a[k], d);
			chk8(m, d);
			mimc_host_model_inst.wr(rst_a[k], 8'h00);
		end
		chk1(1'b0, intrusion_oe);
		mimc_host_model_inst.wr(OFS_VID_TOP, 8'h54);
		mimc_host_model_inst.rd(OFS_VID_TOP, d);
		chk8(8'h55, d);
		mimc_host_model_inst.wr(OFS_CFG_SECOND, 8'h38);
		mimc_host_model_inst.rd(OFS_CFG_SECOND, d);
		chk8(8'h08, d);
		chk1(1'b1, thermal_out_mode);
		mimc_host_model_inst.wr(OFS_CFG_SECOND, 8'h00);
		for (i = 0; i < 4; i++) begin
			mimc_host_model_inst.wr(OFS_VID_FAN, {i[1:0], i[1:0], 4'h5});
			mimc_host_model_inst.rd(OFS_VID_FAN, d);
			chk8({i[1:0], i[1:0], 4'hA}, d);
			chk8(8'h01 << i, {4'h0, fan_a_divisor});
			chk8(8'h01 << i, {4'h0, fan_b_divisor});
		end
		$display("test register_access done");
		// each flag against its own mask bit, then all others masked
		@(posedge ref_clk);
		int_out_en <= 1'b1;
		for (i = 0; i < 16; i++) begin
			if (i == 10 || i == 11) continue;
			m = 8'h01 << (i % 8);
			a = (i < 8) ? OFS_MASK_FIRST : OFS_MASK_SECOND;
			mimc_host_model_inst.wr(a, m);
			src((i < 8) ? m : 8'h00, (i < 8) ? 8'h00 : m);
			chk1(1'b1, int_n);
			mimc_host_model_inst.wr(a, ~m);
			src((i < 8) ? m : 8'h00, (i < 8) ? 8'h00 : m);
			chk1(1'b0, int_n);
			mimc_host_model_inst.wr(a, 8'h00);
		end
		src(8'h00, 8'h0C);
		chk1(1'b1, int_n);
		@(posedge ref_clk);
		int_out_en <= 1'b0;
		src(8'hFF, 8'hF3);
		chk1(1'b1, int_n);
		@(posedge ref_clk);
		int_out_en <= 1'b1;
		src(8'h00, 8'h20);
		chk1(1'b0, int_n);
		mimc_host_model_inst.wr(OFS_CFG_SECOND, 8'h01);
		src(8'h00, 8'h20);
		chk1(1'b1, int_n);
		src(8'h00, 8'h21);
		chk1(1'b0, int_n);
		mimc_host_model_inst.wr(OFS_CFG_SECOND, 8'h40);
		@(posedge ref_clk);
		voltage_id_low <= 4'h8;
		voltage_id_top <= 1'b0;
		src(8'h00, 8'h00);
		chk1(1'b1, int_n);
		@(posedge ref_clk);
		shared_pin_irq_mode <= 1'b1;
		src(8'h00, 8'h00);
		chk1(1'b0, int_n);
		mimc_host_model_inst.wr(OFS_CFG_SECOND, 8'h80);
		src(8'h00, 8'h00);
		chk1(1'b1, int_n);
		@(posedge ref_clk);
		voltage_id_top <= 1'b1;
		src(8'h00, 8'h00);
		chk1(1'b0, int_n);
		$display("test interrupt_gating done");
		// limit locks hold against writes until reinit
		mimc_host_model_inst.wr(OFS_INT_HI_LIM, 8'h5A);
		src(8'h00, 8'h00);
		chk8(8'h01, 8'(iw_cnt));
		chk8(8'h5A, lim_d);
		mimc_host_model_inst.wr(OFS_CFG_SECOND, 8'h06);
		mimc_host_model_inst.wr(OFS_INT_HI_LIM, 8'h11);
		mimc_host_model_inst.wr(OFS_EXT_HI_LIM, 8'h22);
		mimc_host_model_inst.wr(OFS_CFG_SECOND, 8'h00);
		src(8'h00, 8'h00);
		chk8(8'h01, 8'(iw_cnt));
		chk8(8'h00, 8'(ew_cnt));
		chk1(1'b1, int_hi_limit_lock & ext_hi_limit_lock);
		mimc_host_model_inst.rd(OFS_CFG_SECOND, d);
		chk8(8'h06, d);
		mimc_host_model_inst.wr(OFS_MASK_FIRST, 8'h0F);
		mimc_host_model_inst.reinit();
		mimc_host_model_inst.rd(OFS_CFG_SECOND, d);
		chk8(8'h00, d);
		mimc_host_model_inst.rd(OFS_MASK_FIRST, d);
		chk8(8'h00, d);
		mimc_host_model_inst.wr(OFS_EXT_HI_LIM, 8'hA5);
		src(8'h00, 8'h00);
		chk8(8'h01, 8'(ew_cnt));
		chk8(8'hA5, limit_wdata);
		$display("test limit_locks done");
		// a second start mid-pulse must not stretch it
		oe_cnt = 0;
		mimc_host_model_inst.wr(OFS_INTR_CLEAR, 8'h80);
		mimc_host_model_inst.wr(OFS_INTR_CLEAR, 8'h80);
		mimc_host_model_inst.rd(OFS_INTR_CLEAR, d);
		chk8(8'h80, d);
		chk1(1'b0, intrusion_in);
		n = 0;
		while (intrusion_oe !== 1'b0 && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 200) begin
			fails++;
			stop_test();
		end
		@(posedge ref_clk);
		chk8(8'(PULSE), 8'(oe_cnt));
		mimc_host_model_inst.rd(OFS_INTR_CLEAR, d);
		chk8(8'h00, d);
		chk1(1'b1, intrusion_in);
		$display("test intrusion_pulse done");
		// a power-on reset in mid-run also drops masks and limit locks
		mimc_host_model_inst.wr(OFS_CFG_SECOND, 8'h06);
		mimc_host_model_inst.wr(OFS_MASK_SECOND, 8'hFF);
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		chk1(1'b0, int_hi_limit_lock | ext_hi_limit_lock);
		mimc_host_model_inst.rd(OFS_MASK_SECOND, d);
		chk8(8'h00, d);
		mimc_host_model_inst.rd(OFS_CFG_SECOND, d);
		chk8(8'h00, d);
		$display("test mid_run_reset done");
		stop_test();
	end
endmodule // tb_monitor_irq_mask_config
